// >>> sar_ctrl_pkg.sv
// Constants for the SAR converter control block.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
package sar_ctrl_pkg;

	localparam int           SYS_CLK_HZ      = 25000000;
	localparam int           DIV_W           = 5;
	localparam int           RES_W           = 10;
	localparam int           CNT_W           = 5;
	localparam logic [4:0]   DIV_RESET       = 5'h1F;
	localparam logic [4:0]   TRACK_EXTRA     = 5'h03;
	localparam logic [4:0]   CONV_CLKS_10    = 5'h0E;
	localparam logic [4:0]   CONV_CLKS_8     = 5'h0C;
	localparam logic [9:0]   RESULT_RESET    = 10'h000;
	localparam logic [7:0]   BYTE_ZERO       = 8'h00;
	localparam logic [4:0]   DIV_CLEAR       = 5'h00;
	localparam logic [4:0]   CNT_CLEAR       = 5'h00;

	typedef enum logic [2:0]
	{
		SRC_SOFTWARE = 3'h0,
		SRC_TIMER0   = 3'h1,
		SRC_TIMER2   = 3'h2,
		SRC_TIMER1   = 3'h3,
		SRC_EXTERNAL = 3'h4,
		SRC_TIMER3   = 3'h5
	} start_src_t;

	typedef enum logic [1:0]
	{
		ST_OFF   = 2'h0,
		ST_TRACK = 2'h1,
		ST_DELAY = 2'h2,
		ST_CONV  = 2'h3
	} conv_state_t;

endpackage

// >>> sar_adc_conversion_control.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes all inputs synchronous to sys_clk; timer overflows are one-cycle pulses,
// and the analog SAR returns a code in sar_code valid when the conversion ends.
// Notes on behaviour
// - Conversions happen only while enable set
// - Enable clear holds converter in shutdown
// - 10-bit code stored to result bytes
// - Right 0x03FF, left 0xFFC0, unused bits zero
// - Eight-bit mode: 8 MSBs, high byte
// - Eight-bit conversion two SAR clocks shorter
// - SAR clock divided from system clock
// - Six start sources selectable
// - Codes 000 sw, 001 T0, 010 T2, 011 T1
// - External start acts on rising edge
// - Busy high throughout conversion, cleared after
// - Busy falling edge sets done flag, except when enable clear drops busy
// - Result valid when done flag reads one
// - Timer 2/3 low-byte overflow in 8-bit
// - Delayed tracking adds three SAR clocks
// - No delay: conversion starts at once
// - Internal sources: track when not converting
// - External: track if delayed or input low
// - 8-bit delayed ends at 15th clock
// - 8-bit undelayed ends at 12th clock
// - SAR rate is sysclk over divider plus one
// - Eight-bit mode low byte reads zero
`timescale 1ns/1ns
module sar_adc_conversion_control
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Configuration
	input  wire logic        conv_enable_bit,
	input  wire logic        delayed_track_select,
	input  wire logic [2:0]  start_source_select,
	input  wire logic [4:0]  sar_clock_divider,
	input  wire logic        left_justify_select,
	input  wire logic        eight_bit_mode_select,
	// Triggers
	input  wire logic        busy_write_one,
	input  wire logic        timer0_overflow,
	input  wire logic        timer1_overflow,
	input  wire logic        timer2_overflow,
	input  wire logic        timer2_low_overflow,
	input  wire logic        timer2_eight_bit,
	input  wire logic        timer3_overflow,
	input  wire logic        timer3_low_overflow,
	input  wire logic        timer3_eight_bit,
	input  wire logic        external_convert_start,
	// Done flag clear by software
	input  wire logic        done_clear,
	// Analog SAR interface
	input  wire logic [9:0]  sar_code,
	output logic             sar_powered,
	output logic             sar_tracking,
	output logic             sar_clock_tick,
	// Status and result
	output logic             conv_busy_bit,
	output logic             conv_done_flag,
	output logic             conv_done_pulse,
	output logic [7:0]       result_high_byte,
	output logic [7:0]       result_low_byte
);

	sar_ctrl_pkg::conv_state_t state_r;
	sar_ctrl_pkg::conv_state_t state_nxt;
	logic [4:0]                div_r;
	logic [4:0]                div_nxt;
	logic                      tick_r;
	logic                      tick_nxt;
	logic [4:0]                cnt_r;
	logic [4:0]                cnt_nxt;
	logic                      ext_prev_r;
	logic                      ext_prev_nxt;
	logic                      busy_r;
	logic                      busy_nxt;
	logic                      done_r;
	logic                      done_nxt;
	logic                      done_pulse_r;
	logic                      done_pulse_nxt;
	logic                      track_r;
	logic                      track_nxt;
	logic                      powered_r;
	logic                      powered_nxt;
	logic [7:0]                hi_r;
	logic [7:0]                hi_nxt;
	logic [7:0]                lo_r;
	logic [7:0]                lo_nxt;
	logic                      trigger;
	logic [4:0]                conv_len;

	// Timer event: low-byte overflow when the timer runs split
	function automatic logic timer_event(input logic eight, input logic low_ovf,
		input logic full_ovf);
		return eight ? low_ovf : full_ovf;
	endfunction

	// True on the tick that completes a count
	function automatic logic last_tick(input logic [4:0] count, input logic [4:0] limit);
		return (count + 5'h01) == limit;
	endfunction

	function automatic logic [15:0] format_result(input logic [9:0] code,
		input logic eight, input logic left);
		logic [15:0] word;
		word = 16'h0000;
		if (eight)
			word = {code[9:2], sar_ctrl_pkg::BYTE_ZERO};
		else if (left)
			word = {code, 6'h00};
		else
			word = {6'h00, code};
		return word;
	endfunction

	// Trigger selection from the start-source field
	always_comb
	begin
		trigger = 1'b0;
		case (start_source_select)
			sar_ctrl_pkg::SRC_SOFTWARE: trigger = busy_write_one;
			sar_ctrl_pkg::SRC_TIMER0:   trigger = timer0_overflow;
			sar_ctrl_pkg::SRC_TIMER2:   trigger = timer_event(timer2_eight_bit,
				timer2_low_overflow, timer2_overflow);
			sar_ctrl_pkg::SRC_TIMER1:   trigger = timer1_overflow;
			sar_ctrl_pkg::SRC_EXTERNAL: trigger = external_convert_start && !ext_prev_r;
			sar_ctrl_pkg::SRC_TIMER3:   trigger = timer_event(timer3_eight_bit,
				timer3_low_overflow, timer3_overflow);
			default:                    trigger = 1'b0;
		endcase
		conv_len = eight_bit_mode_select ? sar_ctrl_pkg::CONV_CLKS_8
			: sar_ctrl_pkg::CONV_CLKS_10;
	end

	// SAR clock divider and conversion sequencer
	always_comb
	begin
		div_nxt        = div_r;
		tick_nxt       = 1'b0;
		cnt_nxt        = cnt_r;
		state_nxt      = state_r;
		busy_nxt       = busy_r;
		done_pulse_nxt = 1'b0;
		hi_nxt         = hi_r;
		lo_nxt         = lo_r;
		if (!conv_enable_bit)
		begin
			div_nxt   = 5'h00;
			cnt_nxt   = 5'h00;
			state_nxt = sar_ctrl_pkg::ST_OFF;
			busy_nxt  = 1'b0;
		end
		else
		begin
			if (div_r >= sar_clock_divider)
			begin
				div_nxt  = 5'h00;
				tick_nxt = 1'b1;
			end
			else
				div_nxt = div_r + 5'h01;
			case (state_r)
				sar_ctrl_pkg::ST_OFF:
					state_nxt = sar_ctrl_pkg::ST_TRACK;
				sar_ctrl_pkg::ST_TRACK:
					if (trigger)
					begin
						busy_nxt  = 1'b1;
						cnt_nxt   = 5'h00;
						div_nxt   = 5'h00;
						// Restart the divider so the first tick is a full period away
						tick_nxt  = 1'b0;
						state_nxt = delayed_track_select ? sar_ctrl_pkg::ST_DELAY
							: sar_ctrl_pkg::ST_CONV;
					end
				sar_ctrl_pkg::ST_DELAY:
					if (tick_r)
					begin
						cnt_nxt = cnt_r + 5'h01;
						// Three extra ticks of tracking before conversion
						if (last_tick(cnt_r, sar_ctrl_pkg::TRACK_EXTRA))
						begin
							cnt_nxt   = 5'h00;
							state_nxt = sar_ctrl_pkg::ST_CONV;
						end
					end
				sar_ctrl_pkg::ST_CONV:
					if (tick_r)
					begin
						cnt_nxt = cnt_r + 5'h01;
						// Final tick: capture the code and end the conversion
						if (last_tick(cnt_r, conv_len))
						begin
							{hi_nxt, lo_nxt} = format_result(sar_code,
								eight_bit_mode_select, left_justify_select);
							busy_nxt       = 1'b0;
							done_pulse_nxt = 1'b1;
							cnt_nxt        = 5'h00;
							state_nxt      = sar_ctrl_pkg::ST_TRACK;
						end
					end
				default:
					state_nxt = sar_ctrl_pkg::ST_OFF;
			endcase
		end
	end

	// Status flags: done flag, tracking output and start-pin history
	always_comb
	begin
		ext_prev_nxt = external_convert_start;
		// Set wins over software clear
		if (done_pulse_nxt)
			done_nxt = 1'b1;
		else if (done_clear)
			done_nxt = 1'b0;
		else
			done_nxt = done_r;
		if (state_nxt == sar_ctrl_pkg::ST_TRACK)
			track_nxt = (start_source_select == sar_ctrl_pkg::SRC_EXTERNAL
				&& !delayed_track_select) ? !external_convert_start : 1'b1;
		else
			track_nxt = (state_nxt == sar_ctrl_pkg::ST_DELAY);
	end

	// Divider and sequencer state
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_r      <= sar_ctrl_pkg::ST_OFF;
			div_r        <= sar_ctrl_pkg::DIV_CLEAR;
			tick_r       <= 1'b0;
			cnt_r        <= sar_ctrl_pkg::CNT_CLEAR;
			busy_r       <= 1'b0;
			done_pulse_r <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			div_r        <= div_nxt;
			tick_r       <= tick_nxt;
			cnt_r        <= cnt_nxt;
			busy_r       <= busy_nxt;
			done_pulse_r <= done_pulse_nxt;
		end
	end

	// Status flags and start-pin history
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ext_prev_r <= 1'b0;
			done_r     <= 1'b0;
			track_r    <= 1'b0;
		end
		else
		begin
			ext_prev_r <= ext_prev_nxt;
			done_r     <= done_nxt;
			track_r    <= track_nxt;
		end
	end

	// Result bytes, held between completions
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			hi_r <= sar_ctrl_pkg::BYTE_ZERO;
			lo_r <= sar_ctrl_pkg::BYTE_ZERO;
		end
		else
		begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end

	// Power state: high whenever the enable bit is set
	always_comb
	begin
		powered_nxt = conv_enable_bit;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			powered_r <= 1'b0;
		else
			powered_r <= powered_nxt;
	end

	assign sar_powered      = powered_r;
	assign sar_tracking     = track_r;
	assign sar_clock_tick   = tick_r;
	assign conv_busy_bit    = busy_r;
	assign conv_done_flag   = done_r;
	assign conv_done_pulse  = done_pulse_r;
	assign result_high_byte = hi_r;
	assign result_low_byte  = lo_r;

endmodule

// >>> sar_adc_conversion_control_properties.sv
// Concurrent checks on the converter control ports.
// Assumes one sys_clk domain with synchronous active-high rst; bound below.
`timescale 1ns/1ns
module sar_adc_conversion_control_properties
(
	// Clock, reset, configuration
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       conv_enable_bit,
	input wire logic       left_justify_select,
	input wire logic       eight_bit_mode_select,
	// Status and result
	input wire logic       sar_powered,
	input wire logic       conv_busy_bit,
	input wire logic       conv_done_flag,
	input wire logic       conv_done_pulse,
	input wire logic [7:0] result_high_byte,
	input wire logic [7:0] result_low_byte
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	AST_OFF_IDLE: assert property (!conv_enable_bit |=> !conv_busy_bit)
		else $error("busy while disabled");
	AST_SHUTDOWN: assert property (!conv_enable_bit [*2] |-> !sar_powered)
		else $error("powered while disabled");
	AST_DONE_SET: assert property ($fell(conv_busy_bit) && $past(conv_enable_bit) |->
		conv_done_flag && conv_done_pulse) else $error("busy fell without done");
	AST_PULSE_FALL: assert property (conv_done_pulse |-> $fell(conv_busy_bit))
		else $error("done pulse without busy fall");
	AST_LOW_8: assert property (conv_done_pulse && eight_bit_mode_select |->
		result_low_byte == 8'h00) else $error("low byte not zero in eight-bit mode");
	AST_RIGHT: assert property (conv_done_pulse && !eight_bit_mode_select &&
		!left_justify_select |-> result_high_byte[7:2] == 6'h00) else $error("right pad");
	AST_LEFT: assert property (conv_done_pulse && !eight_bit_mode_select &&
		left_justify_select |-> result_low_byte[5:0] == 6'h00) else $error("left pad");
	AST_HOLD: assert property (!conv_done_pulse |->
		$stable({result_high_byte, result_low_byte})) else $error("result moved");
	cover property (conv_done_pulse && eight_bit_mode_select);
	cover property (conv_done_pulse && left_justify_select);
	cover property (conv_done_pulse && !eight_bit_mode_select && !left_justify_select);
endmodule
bind sar_adc_conversion_control sar_adc_conversion_control_properties i_props (.sys_clk,
	.rst, .conv_enable_bit, .left_justify_select, .eight_bit_mode_select, .sar_powered,
	.conv_busy_bit, .conv_done_flag, .conv_done_pulse, .result_high_byte, .result_low_byte);

// >>> sar_analog_model.sv
// Track-and-hold model of the analog input seen by the SAR.
// Assumes the block's tracking and power outputs; scrambles when unpowered.
`timescale 1ns/1ns
module sar_analog_model
(
	// Control from the block
	input  wire logic       sys_clk,
	input  wire logic       sar_powered,
	input  wire logic       sar_tracking,
	// Level in, held code out
	input  wire logic [9:0] level,
	output logic      [9:0] sar_code
);
	logic [9:0] code_r;
	logic [9:0] code_nxt;
	always_comb
	begin
		code_nxt = code_r;
		if (!sar_powered)
			code_nxt = ~code_r;
		else if (sar_tracking)
			code_nxt = level;
	end
	always_ff @(posedge sys_clk)
		code_r <= code_nxt;
	assign sar_code = code_r;
endmodule

// >>> test_sar_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes the analog model supplies sar_code; triggers are one-cycle pulses.
`timescale 1ns/1ns
module test_sar_adc_conversion_control;
	typedef struct {logic [2:0] s; logic [4:0] d; logic dl; logic e8; logic lj; int b;
		logic rp; logic [9:0] c; logic [15:0] ex;} row_t;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic       en = 1'b1;
	logic       dl = 1'b0;
	logic       e8 = 1'b0;
	logic       lj = 1'b0;
	logic       t8 = 1'b0;
	logic [2:0] src = 3'h0;
	logic [4:0] div = 5'h00;
	logic [8:0] tv = 9'h000;
	logic [9:0] lvl = 10'h000;
	logic [9:0] code;
	logic       pw, trk, busy, done, pulse, tick;
	logic [7:0] hi, lo;
	int         n_fail = 0;
	int         checks = 0;
	int         cyc = 0;
	row_t       rows [8] = '{
		'{3'h0,5'h00,1'b0,1'b0,1'b0,0,1'b0,10'h3FF,16'h03FF},
		'{3'h1,5'h01,1'b1,1'b0,1'b1,1,1'b0,10'h3FF,16'hFFC0},
		'{3'h2,5'h00,1'b0,1'b1,1'b1,2,1'b0,10'h201,16'h8000},
		'{3'h3,5'h02,1'b1,1'b1,1'b0,3,1'b0,10'h100,16'h4000},
		'{3'h4,5'h00,1'b0,1'b0,1'b1,4,1'b0,10'h200,16'h8000},
		'{3'h5,5'h03,1'b0,1'b0,1'b0,5,1'b0,10'h100,16'h0100},
		'{3'h2,5'h00,1'b1,1'b0,1'b0,6,1'b0,10'h001,16'h0001},
		'{3'h0,5'h00,1'b0,1'b0,1'b1,0,1'b1,10'h2AB,16'hAAC0}};
	sar_adc_conversion_control i_dut (.sys_clk(sys_clk), .rst(rst), .conv_enable_bit(en),
		.delayed_track_select(dl), .start_source_select(src), .sar_clock_divider(div),
		.left_justify_select(lj), .eight_bit_mode_select(e8), .busy_write_one(tv[0]),
		.timer0_overflow(tv[1]), .timer1_overflow(tv[3]), .timer2_overflow(tv[2]),
		.timer2_low_overflow(tv[6]), .timer2_eight_bit(t8), .timer3_overflow(tv[5]),
		.timer3_low_overflow(tv[7]), .timer3_eight_bit(t8), .external_convert_start(tv[4]),
		.done_clear(tv[8]), .sar_code(code), .sar_powered(pw), .sar_tracking(trk),
		.sar_clock_tick(tick), .conv_busy_bit(busy), .conv_done_flag(done),
		.conv_done_pulse(pulse), .result_high_byte(hi), .result_low_byte(lo));
	sar_analog_model i_model (.sys_clk(sys_clk), .sar_powered(pw), .sar_tracking(trk),
		.level(lvl), .sar_code(code));
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			close_out();
		end
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic run(input row_t r);
		int n;
		int m;
		int nt;
		n = 0;
		nt = 0;
		m = r.e8 ? int'(sar_ctrl_pkg::CONV_CLKS_8) : int'(sar_ctrl_pkg::CONV_CLKS_10);
		if (r.dl)
			m += int'(sar_ctrl_pkg::TRACK_EXTRA);
		@(posedge sys_clk);
		src <= r.s;
		div <= r.d;
		dl <= r.dl;
		e8 <= r.e8;
		lj <= r.lj;
		lvl <= r.c;
		t8 <= (r.b == 6);
		@(posedge sys_clk);
		tv[r.b] <= 1'b1;
		@(posedge sys_clk);
		tv <= 9'h000;
		@(posedge sys_clk);
		#1;
		chk({15'h0000, trk}, {15'h0000, r.dl});
		while (busy === 1'b1 && n < 999)
		begin
			if (tick === 1'b1)
				nt++;
			n++;
			@(posedge sys_clk);
			tv[r.b] <= r.rp && n == 5;
			#1;
		end
		chk(16'(n), 16'(m * (r.d + 1)));
		chk(16'(nt), 16'(m));
		chk({13'h0000, pulse, done, busy}, 16'h0006);
		chk({hi, lo}, r.ex);
		chk({15'h0000, trk}, 16'h0001);
		@(posedge sys_clk);
		#1;
		chk({15'h0000, busy}, 16'h0000);
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk({hi, lo}, 16'h0000);
		chk({11'h000, pw, trk, busy, done, pulse}, 16'h0000);
		foreach (rows[i])
			run(rows[i]);
		@(posedge sys_clk);
		tv[8] <= 1'b1;
		@(posedge sys_clk);
		tv <= 9'h000;
		@(posedge sys_clk);
		#1;
		chk({15'h0000, done}, 16'h0000);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge sys_clk);
			en <= (k == 0);
			src <= (k == 0) ? 3'h6 : 3'h0;
			@(posedge sys_clk);
			tv <= 9'h03F;
			@(posedge sys_clk);
			tv <= 9'h000;
			repeat (3) @(posedge sys_clk);
			#1;
			chk({14'h0000, busy, pw}, (k == 0) ? 16'h0001 : 16'h0000);
		end
		close_out();
	end
endmodule
